// ===== wtq_map.svh
// Register offsets, field positions, reset values and timing counts of the queue core.
// Assumes a 32-bit word register port with byte addresses.
`ifndef WTQ_MAP_SVH
`define WTQ_MAP_SVH
`define WTQ_A_CTRL     8'h00
`define WTQ_A_RETRY    8'h04
`define WTQ_A_ACKTO    8'h08
`define WTQ_A_STATUS   8'h0c
`define WTQ_A_CNT      8'h40
`define WTQ_F_HUB      0
`define WTQ_F_NEWREV   1
`define WTQ_F_CLR      2
`define WTQ_RST_CTRL   2'h0
`define WTQ_RST_RETRY  4'h4
`define WTQ_CLK_NS     10
`define WTQ_ACK_TO_NS  2000
`define WTQ_ACK_TO_CYC (`WTQ_ACK_TO_NS / `WTQ_CLK_NS)
`define WTQ_LEN_OLD    11'h5ea
`define WTQ_LEN_NEW    11'h640
`define WTQ_VLAN_B     11'h004
`define WTQ_C_ETH_RX   0
`define WTQ_C_ETH_TX   1
`define WTQ_C_TX_TOT   2
`define WTQ_C_BEACON   3
`define WTQ_C_MGMT     4
`define WTQ_C_UCAST    5
`define WTQ_C_SUB      6
`define WTQ_C_SUB_Q    7
`define WTQ_C_DROP     10
`define WTQ_C_RETX     11
`define WTQ_C_CTX      12
`define WTQ_C_TXEV     16
`define WTQ_C_UNDR     17
`define WTQ_C_TXOTH    18
`define WTQ_C_RX_TOT   19
`define WTQ_C_RX_DATA  20
`define WTQ_C_RXEV     21
`define WTQ_C_PHY      22
`define WTQ_C_CRC      23
`define WTQ_C_OVR      24
`define WTQ_C_DEC      25
`define WTQ_C_CRX      26
`define WTQ_C_DUP      30
`define WTQ_C_POL      31
`define WTQ_C_FRAG     32
`define WTQ_NCNT       33
`endif

// ===== wtq_pkg.sv
// Types shared by the queue core and its surroundings.
// Assumes wtq_map.svh supplies the numeric map.
package wtq_pkg;
  typedef enum logic [1:0] {
    WTQ_K_DATA   = 2'b00,
    WTQ_K_CTRL   = 2'b01,
    WTQ_K_MGMT   = 2'b10,
    WTQ_K_BEACON = 2'b11
  } wtq_kind_t;
  typedef struct packed {
    logic [7:0] id;
    wtq_kind_t  kind;
    logic       group;
    logic [1:0] cat;
  } wtq_desc_t;
  typedef struct packed {
    wtq_desc_t d;
    logic      qsel_hi;
    logic      to_radio;
    logic      internal;
  } wtq_enq_t;
  typedef struct packed {
    wtq_kind_t   kind;
    logic [11:0] seq;
    logic        retry;
    logic        phy_err;
    logic        crc_err;
    logic        dec_err;
    logic        overrun;
    logic [1:0]  cat;
  } wtq_rx_t;
  typedef enum logic [1:0] {
    WTQ_TX_IDLE = 2'b00,
    WTQ_TX_WAIT = 2'b01
  } wtq_txst_t;
endpackage

// ===== wtq_core.sv
// Frame queueing, acknowledgement and traffic counters of the bridge.
// Assumes all inputs are synchronous to clock and event inputs are one-cycle pulses.
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "wtq_map.svh"
module wtq_core #(
  parameter int QD = 4,
  parameter int CW = 32
) (
  input  wire logic              clock,        // System clock.
  input  wire logic              reset_n,      // Asynchronous reset.
  input  wire logic [7:0]        reg_addr,     // Register byte address.
  input  wire logic [31:0]       reg_wdata,    // Write data.
  input  wire logic              reg_wr,       // Write strobe.
  input  wire logic              reg_rd,       // Read strobe.
  output logic [31:0]            reg_rdata,    // Read data, cycle after strobe.
  input  wire logic              eth_rx_valid, // Ethernet frame arrived.
  input  wire logic [10:0]       eth_rx_len,   // Length without CRC.
  input  wire logic [1:0]        eth_rx_tags,  // VLAN tag count.
  input  wire logic              eth_rx_pass,  // Address filter passed.
  output logic                   eth_rx_ok,    // Frame accepted pulse.
  input  wire logic              eth_tx_valid, // Frame to send to Ethernet.
  input  wire logic [10:0]       eth_tx_len,   // Length without CRC.
  input  wire logic [1:0]        eth_tx_tags,  // VLAN tag count.
  output logic                   eth_tx_ok,    // Frame sent pulse.
  input  wire logic              enq_valid,    // Descriptor offered.
  input  wire wtq_pkg::wtq_enq_t enq_data,     // Descriptor and routing.
  output logic                   enq_ready,    // Room in every queue.
  input  wire logic              radio_ready,  // Radio can take a frame.
  output logic                   radio_valid,  // Frame start pulse.
  output wtq_pkg::wtq_desc_t     radio_desc,   // Frame on air.
  input  wire logic              radio_ack,    // Acknowledgement seen.
  input  wire logic              tx_underrun,  // Transmit aborted, underrun.
  input  wire logic              tx_other,     // Transmit incomplete, other.
  input  wire logic              rx_valid,     // Wireless frame received.
  input  wire wtq_pkg::wtq_rx_t  rx_data,      // Receive status.
  output logic                   rx_fwd,       // Forward to Ethernet pulse.
  input  wire logic              rx_bad_frag,  // Fragment with CRC error.
  input  wire logic              pol_drop      // Policer discarded a frame.
);
  import wtq_pkg::*;

  localparam int PW = $clog2(QD);

  initial begin
    if (QD < 2 || (1 << PW) != QD) $error("QD must be a power of two, at least 2");
    if (CW < 8 || CW > 32) $error("CW must lie in 8..32");
  end

  logic [1:0]            ctrl_r;
  logic [3:0]            retry_lim_r;
  logic [15:0]           ack_to_r;
  logic                  clr;
  logic [`WTQ_NCNT-1:0]  inc;
  logic [CW-1:0]         cnt_r [`WTQ_NCNT];
  wtq_desc_t             qmem_r [3][QD];
  logic [PW-1:0]         wp_r [3];
  logic [PW-1:0]         rp_r [3];
  logic [PW:0]           qcnt_r [3];
  logic [2:0]            push;
  logic [2:0]            pop;
  logic [1:0]            enq_q;
  logic                  enq_fire;
  wtq_txst_t             tx_st_r;
  wtq_desc_t             cur_r;
  logic [15:0]           timer_r;
  logic [3:0]            tries_r;
  logic                  timeout;
  logic                  drop;
  logic                  sent;
  logic [10:0]           rx_eff;
  logic [10:0]           tx_eff;
  logic                  rx_len_ok;
  logic                  tx_len_ok;
  logic                  rx_bad;
  logic                  rx_dup;
  logic [11:0]           last_seq_r;
  logic [31:0]           rd_nxt;

  assign clr = reg_wr && reg_addr == `WTQ_A_CTRL && reg_wdata[`WTQ_F_CLR];

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r      <= `WTQ_RST_CTRL;
      retry_lim_r <= `WTQ_RST_RETRY;
      ack_to_r    <= 16'(`WTQ_ACK_TO_CYC);
    end else if (reg_wr) begin
      if (reg_addr == `WTQ_A_CTRL) begin
        ctrl_r <= {reg_wdata[`WTQ_F_NEWREV], reg_wdata[`WTQ_F_HUB]};
      end else if (reg_addr == `WTQ_A_RETRY) begin
        retry_lim_r <= reg_wdata[3:0];
      end else if (reg_addr == `WTQ_A_ACKTO) begin
        // A zero timeout would wrap and wait 65536 cycles to expire, so one cycle is the floor.
        ack_to_r <= (reg_wdata[15:0] == 16'h0000) ? 16'h0001 : reg_wdata[15:0];
      end
    end
  end

  // Old parts take only untagged frames; new parts measure the frame with its tags included.
  assign rx_eff = eth_rx_len - ((eth_rx_tags == 2'h0) ? 11'h000 :
                  (eth_rx_tags == 2'h1) ? `WTQ_VLAN_B : (`WTQ_VLAN_B << 1));
  assign tx_eff = eth_tx_len - ((eth_tx_tags == 2'h0) ? 11'h000 :
                  (eth_tx_tags == 2'h1) ? `WTQ_VLAN_B : (`WTQ_VLAN_B << 1));
  assign rx_len_ok = ctrl_r[`WTQ_F_NEWREV] ? (eth_rx_len <= `WTQ_LEN_NEW)
                   : (eth_rx_tags == 2'h0 && rx_eff <= `WTQ_LEN_OLD);
  assign tx_len_ok = ctrl_r[`WTQ_F_NEWREV] ? (eth_tx_len <= `WTQ_LEN_NEW)
                   : (eth_tx_tags == 2'h0 && tx_eff <= `WTQ_LEN_OLD);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      eth_rx_ok <= 1'b0;
      eth_tx_ok <= 1'b0;
    end else begin
      eth_rx_ok <= eth_rx_valid && eth_rx_pass && rx_len_ok;
      eth_tx_ok <= eth_tx_valid && tx_len_ok;
    end
  end

  always_comb begin
    enq_q = enq_data.qsel_hi ? 2'd0 : 2'd2;
    if (enq_data.d.group && ctrl_r[`WTQ_F_HUB]) begin
      enq_q = 2'd1;
    end
    if (enq_data.internal || enq_data.to_radio) begin
      enq_q = 2'd0;
    end
  end

  assign enq_fire = enq_valid && enq_ready;

  always_comb begin
    pop = 3'b000;
    if (tx_st_r == WTQ_TX_IDLE && radio_ready) begin
      if (qcnt_r[0] != '0) begin
        pop = 3'b001;
      end else if (qcnt_r[1] != '0) begin
        pop = 3'b010;
      end else if (qcnt_r[2] != '0) begin
        pop = 3'b100;
      end
    end
  end

  genvar q;
  generate
    for (q = 0; q < 3; q++) begin : g_q
      assign push[q] = enq_fire && enq_q == 2'(q);
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          wp_r[q]   <= '0;
          rp_r[q]   <= '0;
          qcnt_r[q] <= '0;
        end else begin
          if (push[q]) begin
            qmem_r[q][wp_r[q]] <= enq_data.d;
            wp_r[q]            <= wp_r[q] + 1'b1;
          end
          if (pop[q]) begin
            rp_r[q] <= rp_r[q] + 1'b1;
          end
          qcnt_r[q] <= qcnt_r[q] + (PW+1)'(push[q]) - (PW+1)'(pop[q]);
        end
      end
    end
  endgenerate

  // Ready is registered, so it must promise room even if a push lands this cycle.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      enq_ready <= 1'b0;
    end else begin
      enq_ready <= qcnt_r[0] < (PW+1)'(QD - 2) && qcnt_r[1] < (PW+1)'(QD - 2)
                && qcnt_r[2] < (PW+1)'(QD - 2)
                || (!enq_fire && qcnt_r[0] < (PW+1)'(QD - 1)
                    && qcnt_r[1] < (PW+1)'(QD - 1) && qcnt_r[2] < (PW+1)'(QD - 1));
    end
  end

  assign timeout = tx_st_r == WTQ_TX_WAIT && !radio_ack && timer_r == 16'h0001;
  assign drop    = timeout && tries_r == retry_lim_r;
  assign sent    = (pop != 3'b000 && radio_desc_grp(pop)) ||
                   (tx_st_r == WTQ_TX_WAIT && radio_ack);

  function automatic logic radio_desc_grp(input logic [2:0] p);
    radio_desc_grp = p[0] ? qmem_r[0][rp_r[0]].group :
                     p[1] ? qmem_r[1][rp_r[1]].group : qmem_r[2][rp_r[2]].group;
  endfunction

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tx_st_r     <= WTQ_TX_IDLE;
      cur_r       <= '0;
      radio_desc  <= '0;
      radio_valid <= 1'b0;
      timer_r     <= 16'h0000;
      tries_r     <= 4'h0;
    end else begin
      radio_valid <= 1'b0;
      case (tx_st_r)
        WTQ_TX_IDLE: begin
          if (pop != 3'b000) begin
            radio_valid <= 1'b1;
            radio_desc  <= pop[0] ? qmem_r[0][rp_r[0]] :
                           pop[1] ? qmem_r[1][rp_r[1]] : qmem_r[2][rp_r[2]];
            cur_r       <= pop[0] ? qmem_r[0][rp_r[0]] :
                           pop[1] ? qmem_r[1][rp_r[1]] : qmem_r[2][rp_r[2]];
            tries_r     <= 4'h0;
            timer_r     <= ack_to_r;
            if (!radio_desc_grp(pop)) begin
              tx_st_r <= WTQ_TX_WAIT;
            end
          end
        end
        WTQ_TX_WAIT: begin
          if (radio_ack) begin
            tx_st_r <= WTQ_TX_IDLE;
          end else if (drop) begin
            tx_st_r <= WTQ_TX_IDLE;
          end else if (timeout) begin
            radio_valid <= 1'b1;
            radio_desc  <= cur_r;
            tries_r     <= tries_r + 4'h1;
            timer_r     <= ack_to_r;
          end else begin
            timer_r <= timer_r - 16'h0001;
          end
        end
        default: tx_st_r <= WTQ_TX_IDLE;
      endcase
    end
  end

  assign rx_bad = rx_data.phy_err || rx_data.crc_err || rx_data.dec_err || rx_data.overrun;
  assign rx_dup = rx_data.kind == WTQ_K_DATA && rx_data.retry && rx_data.seq == last_seq_r;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      last_seq_r <= 12'h000;
      rx_fwd     <= 1'b0;
    end else begin
      rx_fwd <= rx_valid && !rx_bad && rx_data.kind == WTQ_K_DATA && !rx_dup;
      if (rx_valid && !rx_bad && rx_data.kind == WTQ_K_DATA) begin
        last_seq_r <= rx_data.seq;
      end
    end
  end

  always_comb begin
    logic [1:0] tc;
    logic       hub;
    logic       rg;
    tc  = sent ? (tx_st_r == WTQ_TX_WAIT ? cur_r.cat : radio_desc_cat(pop)) : 2'h0;
    hub = ctrl_r[`WTQ_F_HUB];
    rg  = rx_valid && !rx_bad;
    inc = '0;
    inc[`WTQ_C_ETH_RX] = eth_rx_valid && eth_rx_pass;
    inc[`WTQ_C_ETH_TX] = eth_tx_valid && tx_len_ok;
    inc[`WTQ_C_TX_TOT] = sent;
    inc[`WTQ_C_UCAST]  = hub && tx_st_r == WTQ_TX_WAIT && radio_ack;
    inc[`WTQ_C_BEACON] = hub && sent && radio_desc_kind(pop) == WTQ_K_BEACON;
    inc[`WTQ_C_MGMT]   = hub && sent && radio_desc_kind(pop) != WTQ_K_BEACON;
    inc[`WTQ_C_SUB]    = enq_fire && !enq_data.internal && enq_data.d.kind == WTQ_K_DATA;
    for (int i = 0; i < 3; i++) begin
      inc[`WTQ_C_SUB_Q + i] = inc[`WTQ_C_SUB] && push[i];
    end
    inc[`WTQ_C_DROP]   = drop;
    inc[`WTQ_C_RETX]   = timeout;
    inc[`WTQ_C_CTX]    = tc != 2'h0;
    inc[`WTQ_C_CTX + 1 + tc - 1] = tc != 2'h0;
    inc[`WTQ_C_UNDR]   = tx_underrun;
    inc[`WTQ_C_TXOTH]  = tx_other;
    inc[`WTQ_C_TXEV]   = drop || tx_underrun || tx_other;
    inc[`WTQ_C_RX_TOT] = rg && !rx_dup;
    inc[`WTQ_C_RX_DATA] = rg && rx_data.kind == WTQ_K_DATA;
    inc[`WTQ_C_PHY]    = rx_valid && rx_data.phy_err;
    inc[`WTQ_C_CRC]    = rx_valid && rx_data.crc_err;
    inc[`WTQ_C_OVR]    = rx_valid && rx_data.overrun;
    inc[`WTQ_C_DEC]    = rx_valid && rx_data.dec_err;
    inc[`WTQ_C_RXEV]   = rx_valid && rx_bad;
    inc[`WTQ_C_CRX]    = rg && rx_data.cat != 2'h0;
    inc[`WTQ_C_CRX + 1 + rx_data.cat - 1] = rg && rx_data.cat != 2'h0;
    inc[`WTQ_C_DUP]    = rg && rx_dup;
    inc[`WTQ_C_POL]    = pol_drop;
    inc[`WTQ_C_FRAG]   = rx_bad_frag;
  end

  function automatic logic [1:0] radio_desc_cat(input logic [2:0] p);
    radio_desc_cat = p[0] ? qmem_r[0][rp_r[0]].cat :
                     p[1] ? qmem_r[1][rp_r[1]].cat : qmem_r[2][rp_r[2]].cat;
  endfunction

  function automatic wtq_kind_t radio_desc_kind(input logic [2:0] p);
    if (p == 3'b000) begin
      radio_desc_kind = cur_r.kind;
    end else begin
      radio_desc_kind = p[0] ? qmem_r[0][rp_r[0]].kind :
                        p[1] ? qmem_r[1][rp_r[1]].kind : qmem_r[2][rp_r[2]].kind;
    end
  endfunction

  genvar c;
  generate
    for (c = 0; c < `WTQ_NCNT; c++) begin : g_cnt
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          cnt_r[c] <= '0;
        end else if (clr) begin
          cnt_r[c] <= '0;
        end else begin
          cnt_r[c] <= cnt_r[c] + CW'(inc[c]);
        end
      end
    end
  endgenerate

  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (reg_addr == `WTQ_A_CTRL) begin
      rd_nxt = {30'h0, ctrl_r};
    end else if (reg_addr == `WTQ_A_RETRY) begin
      rd_nxt = {28'h0, retry_lim_r};
    end else if (reg_addr == `WTQ_A_ACKTO) begin
      rd_nxt = {16'h0, ack_to_r};
    end else if (reg_addr == `WTQ_A_STATUS) begin
      rd_nxt = {14'h0, 2'(tx_st_r), tries_r, 1'b0, 3'(qcnt_r[2]), 1'b0, 3'(qcnt_r[1]),
                1'b0, 3'(qcnt_r[0])};
    end else if (reg_addr >= `WTQ_A_CNT && reg_addr[1:0] == 2'h0
                 && 6'(reg_addr[7:2] - 6'h10) < 6'(`WTQ_NCNT)) begin
      rd_nxt = 32'(cnt_r[6'(reg_addr[7:2] - 6'h10)]);
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_rd ? rd_nxt : 32'h0000_0000;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence s_grp_send;
    pop != 3'b000 ##0 radio_desc_grp(pop);
  endsequence
  sequence s_expire;
    tx_st_r == WTQ_TX_WAIT && !radio_ack && timer_r == 16'h0001;
  endsequence

  AST_CLEAR: assert property (clr |=> cnt_r[`WTQ_C_DROP] == '0 && cnt_r[0] == '0)
    else $error("counters not cleared");
  AST_FILTER: assert property (eth_rx_valid && !eth_rx_pass && !clr
    |=> cnt_r[`WTQ_C_ETH_RX] == $past(cnt_r[`WTQ_C_ETH_RX]) && !eth_rx_ok)
    else $error("filtered frame counted");
  AST_OLD_LEN: assert property (eth_rx_valid && !ctrl_r[`WTQ_F_NEWREV]
    && eth_rx_len > `WTQ_LEN_OLD |=> !eth_rx_ok)
    else $error("oversize frame accepted");
  AST_PRIO: assert property (pop[1] || pop[2] |-> qcnt_r[0] == '0
    && (pop[1] || qcnt_r[1] == '0))
    else $error("lower queue served first");
  AST_HIGH: assert property (enq_fire && enq_data.internal |-> push == 3'b001)
    else $error("internal frame not in high queue");
  AST_RESEND: assert property (s_expire ##0 tries_r != retry_lim_r
    |=> radio_valid && radio_desc == cur_r && timer_r == ack_to_r)
    else $error("no resend on timeout");
  AST_DROP: assert property (s_expire ##0 tries_r == retry_lim_r && !clr
    |=> tx_st_r == WTQ_TX_IDLE && !radio_valid
    && cnt_r[`WTQ_C_DROP] == $past(cnt_r[`WTQ_C_DROP]) + 1'b1)
    else $error("drop not taken");
  AST_ONCE: assert property (s_grp_send |=> tx_st_r == WTQ_TX_IDLE && radio_valid
    && radio_desc.group)
    else $error("group frame awaited ack");
  AST_DUP: assert property (rx_valid && !rx_bad && rx_dup |=> !rx_fwd)
    else $error("duplicate forwarded");
endmodule
`default_nettype wire

// ===== wtq_radio_model.sv
// Behavioural radio side of the queue core: takes frames and acknowledges attempts.
// Assumes the bench steers ack_on and ready_on between scenarios.
`timescale 1ns/10ps
`default_nettype none
module wtq_radio_model (
  input  wire logic clock,       // System clock.
  input  wire logic reset_n,     // Asynchronous reset.
  input  wire logic radio_valid, // Attempt start pulse.
  input  wire logic radio_group, // Attempt carries a group frame.
  input  wire logic ack_on,      // Acknowledge attempts when high.
  input  wire logic ready_on,    // Accept frames when high.
  output logic      radio_ack,   // Acknowledgement pulse.
  output logic      radio_ready  // Radio can take a frame.
);
  logic [2:0] dly_r;

  // The ack lands a few cycles after the attempt, well inside the timeout.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      dly_r       <= 3'h0;
      radio_ack   <= 1'b0;
      radio_ready <= 1'b0;
    end else begin
      // Group frames are never acknowledged by a real receiver.
      dly_r       <= {dly_r[1:0], radio_valid & ack_on & !radio_group};
      radio_ack   <= dly_r[2];
      radio_ready <= ready_on;
    end
  end
endmodule
`default_nettype wire

// ===== test_wireless_tx_queue_and_traffic_stats.sv
// Self-checking bench: registers, Ethernet limits, queues, retries, receive and clear.
// Assumes wtq_radio_model plays the radio; every wait is bounded.
`timescale 1ns/10ps
`default_nettype none
`include "wtq_map.svh"
module test_wireless_tx_queue_and_traffic_stats;
  import wtq_pkg::*;
  logic        clock = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, v;
  logic        eth_rx_valid = 1'b0, eth_rx_pass = 1'b0, eth_rx_ok;
  logic        eth_tx_valid = 1'b0, eth_tx_ok, enq_valid = 1'b0, enq_ready;
  logic [10:0] eth_len = 11'h0;
  logic [1:0]  eth_tags = 2'h0;
  wtq_enq_t    enq_data = '0;
  wtq_desc_t   radio_desc;
  wtq_rx_t     rx_data = '0;
  logic        radio_ready, radio_valid, radio_ack, rx_valid = 1'b0, rx_fwd;
  logic        ack_on = 1'b1, ready_on = 1'b1;
  logic [3:0]  ev = 4'h0;
  logic [7:0]  ids[$];
  int          miscompares = 0, comparisons = 0;

  always #5 clock = ~clock;
  always @(posedge clock) if (radio_valid === 1'b1) ids.push_back(radio_desc.id);

  wtq_core dut (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .eth_rx_valid(eth_rx_valid), .eth_rx_len(eth_len), .eth_rx_tags(eth_tags),
    .eth_rx_pass(eth_rx_pass), .eth_rx_ok(eth_rx_ok), .eth_tx_valid(eth_tx_valid),
    .eth_tx_len(eth_len), .eth_tx_tags(eth_tags), .eth_tx_ok(eth_tx_ok),
    .enq_valid(enq_valid), .enq_data(enq_data), .enq_ready(enq_ready),
    .radio_ready(radio_ready), .radio_valid(radio_valid), .radio_desc(radio_desc),
    .radio_ack(radio_ack), .tx_underrun(ev[0]), .tx_other(ev[1]), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_fwd(rx_fwd), .rx_bad_frag(ev[2]), .pol_drop(ev[3]));
  wtq_radio_model radio (.clock(clock), .reset_n(reset_n), .radio_valid(radio_valid),
    .radio_group(radio_desc.group),
    .ack_on(ack_on), .ready_on(ready_on), .radio_ack(radio_ack), .radio_ready(radio_ready));

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic cc(input int i, input logic [31:0] e);
    rd(8'(`WTQ_A_CNT + 4 * i), v);
    chk($sformatf("cnt%0d", i), e, v);
  endtask
  task automatic eth(input logic tx, input logic [10:0] l, input logic [1:0] t,
                     input logic p, input logic e);
    @(posedge clock);
    eth_rx_valid <= !tx;
    eth_tx_valid <= tx;
    eth_len <= l;
    eth_tags <= t;
    eth_rx_pass <= p;
    @(posedge clock);
    eth_rx_valid <= 1'b0;
    eth_tx_valid <= 1'b0;
    #1 chk("eth_ok", e, tx ? eth_tx_ok : eth_rx_ok);
  endtask
  task automatic enq(input logic [7:0] id, input wtq_kind_t k, input logic g, h, r, i);
    int n;
    @(posedge clock);
    enq_valid <= 1'b1;
    enq_data <= '{d: '{id: id, kind: k, group: g, cat: 2'h0},
                  qsel_hi: h, to_radio: r, internal: i};
    // The offer must stand until an edge at which the core samples ready high.
    @(posedge clock);
    for (n = 0; n < 50 && enq_ready !== 1'b1; n++) @(posedge clock);
    chk("enq_ready", 1'b1, enq_ready);
    enq_valid <= 1'b0;
  endtask
  task automatic idle;
    for (int n = 0; n < 300; n++) begin
      rd(`WTQ_A_STATUS, v);
      if ((v & 32'h0003_0777) === 32'h0) return;
    end
    miscompares++;
    test_done;
  endtask
  task automatic rx(input logic [11:0] s, input logic r, c, f, input logic [1:0] k);
    @(posedge clock);
    rx_valid <= 1'b1;
    rx_data <= '{kind: c ? WTQ_K_CTRL : WTQ_K_DATA, seq: s, retry: r, phy_err: 1'b0,
                 crc_err: c, dec_err: 1'b0, overrun: 1'b0, cat: k};
    @(posedge clock);
    rx_valid <= 1'b0;
    #1 chk("rx_fwd", f, rx_fwd);
  endtask
  task automatic test_done;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    rd(`WTQ_A_RETRY, v);
    chk("retry", 32'h4, v);
    rd(`WTQ_A_ACKTO, v);
    chk("ackto", 32'hc8, v);
    rd(8'hfc, v);
    chk("unmapped", 32'h0, v);
    wr(`WTQ_A_CTRL, 32'h1);
    eth(1'b0, 11'h040, 2'h0, 1'b0, 1'b0);
    eth(1'b0, 11'h5ea, 2'h0, 1'b1, 1'b1);
    eth(1'b0, 11'h5eb, 2'h0, 1'b1, 1'b0);
    eth(1'b0, 11'h5ea, 2'h1, 1'b1, 1'b0);
    cc(0, 32'h3);
    eth(1'b1, 11'h5ea, 2'h0, 1'b1, 1'b1);
    eth(1'b1, 11'h5eb, 2'h0, 1'b1, 1'b0);
    cc(1, 32'h1);
    wr(`WTQ_A_CTRL, 32'h3);
    eth(1'b0, 11'h640, 2'h2, 1'b1, 1'b1);
    eth(1'b0, 11'h641, 2'h0, 1'b1, 1'b0);
    wr(`WTQ_A_ACKTO, 32'h14);
    enq(8'h01, WTQ_K_DATA, 1'b0, 1'b0, 1'b0, 1'b0);
    idle;
    cc(2, 32'h1);
    cc(5, 32'h1);
    cc(4, 32'h1);
    cc(6, 32'h1);
    cc(9, 32'h1);
    ack_on <= 1'b0;
    ids.delete();
    enq(8'h02, WTQ_K_DATA, 1'b1, 1'b0, 1'b0, 1'b0);
    idle;
    chk("group_tries", 32'h1, ids.size());
    cc(2, 32'h2);
    cc(8, 32'h1);
    wr(`WTQ_A_RETRY, 32'h2);
    ids.delete();
    enq(8'h03, WTQ_K_DATA, 1'b0, 1'b0, 1'b0, 1'b0);
    idle;
    chk("tries", 32'h3, ids.size());
    cc(10, 32'h1);
    cc(11, 32'h3);
    cc(16, 32'h1);
    cc(2, 32'h2);
    ack_on <= 1'b1;
    ready_on <= 1'b0;
    ids.delete();
    enq(8'h04, WTQ_K_DATA, 1'b0, 1'b0, 1'b0, 1'b0);
    enq(8'h05, WTQ_K_MGMT, 1'b0, 1'b0, 1'b0, 1'b1);
    enq(8'h06, WTQ_K_DATA, 1'b1, 1'b0, 1'b0, 1'b0);
    enq(8'h07, WTQ_K_DATA, 1'b0, 1'b0, 1'b1, 1'b0);
    ready_on <= 1'b1;
    idle;
    chk("first", 32'h5, ids[0]);
    chk("second", 32'h7, ids[1]);
    chk("third", 32'h6, ids[2]);
    chk("fourth", 32'h4, ids[3]);
    cc(7, 32'h1);
    rx(12'h005, 1'b0, 1'b0, 1'b1, 2'h2);
    rx(12'h005, 1'b1, 1'b0, 1'b0, 2'h0);
    rx(12'h006, 1'b0, 1'b1, 1'b0, 2'h0);
    cc(26, 32'h1);
    cc(28, 32'h1);
    cc(19, 32'h1);
    cc(20, 32'h2);
    cc(30, 32'h1);
    cc(23, 32'h1);
    cc(21, 32'h1);
    @(posedge clock);
    ev <= 4'hf;
    @(posedge clock);
    ev <= 4'h0;
    cc(17, 32'h1);
    cc(18, 32'h1);
    cc(16, 32'h2);
    cc(31, 32'h1);
    wr(`WTQ_A_CTRL, 32'h7);
    rd(`WTQ_A_CTRL, v);
    chk("ctrl", 32'h3, v);
    for (int i = 0; i < `WTQ_NCNT; i++) cc(i, 32'h0);
    test_done;
  end
endmodule
`default_nettype wire
